// ---- rtl/waveform_ram_sequencer.sv ----
// Purpose: Waveform RAM with two segment registers and an address sequencer.
// Assumes: Serial word and baseband sample strobes come from logic on aclk.
// Notes: The trigger pin is asynchronous and passes two flip-flops first.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.

`timescale 1ns/100ps

// What this block does
// - 1024x32 memory, usable only in upconvert/interpolate modes
// - Enable bit picks load/retrieve or playback
// - Destination bit steers to scaling or chain
// - Chain destination in playback (enable set) disables parallel sample input
// - Control changes act only on update/profile change
// - Upper half in-phase, lower half quadrature
// - Chain: half in top bits, sign fills two
// - Scaling: halves are unsigned sixteen-bit fractions
// - Segments hold start, end, rate, mode
// - Sequencer paced by serial words or samples
// - Active segment mode steers the sequence
// - Trigger edges start; rise seg0, fall seg1
// - Serial transfers advance address upward per word in load mode only
// - Overlapping segments allowed; last write wins
// - Mode codes 001..100 valid, others invalid
// - Serial transfers take priority over playback
module waveform_ram_sequencer
	import waveform_ram_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic memory_trigger_pin,
	input wire logic profile_change,
	input wire logic sample_tick,
	output chain_s chain_out,
	output logic chain_valid,
	output scale_s scale_out,
	output logic parallel_port_enable
);

	// ==========================================================
	// Byte-lane merge used by the control and segment registers.
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction : apply_strb

	// Unpacks a segment register pair into the sequencer's view.
	function automatic seg_s to_seg(input logic [31:0] aw, input logic [31:0] cw);
		seg_s s;
		s.first = aw[ADDR_W-1:0];
		s.stop = aw[SEG_STOP_LSB +: ADDR_W];
		s.rate = cw[15:0];
		s.mode = cw[SEG_MODE_LSB +: 3];
		return s;
	endfunction : to_seg

	// ==========================================================
	// Bus state
	logic aw_held; // Write address taken, waiting for its data.
	logic [7:0] aw_addr_q; // Held write address.
	logic w_held; // Write data taken, waiting for its address.
	logic [31:0] w_data_q; // Held write data.
	logic [3:0] w_strb_q; // Held byte enables.
	logic rd_pend; // Read taken; answer goes out next cycle.
	logic [7:0] ar_addr_q; // Held read address.

	// Software-written (pending) and active copies of control state.
	logic [31:0] ctrl_pend;
	logic [31:0] seg_addr_pend [2];
	logic [31:0] seg_cfg_pend [2];
	logic act_en; // Active memory enable.
	logic act_dest; // Active destination, set for baseband chain.
	logic [1:0] act_opm; // Active operating mode.
	seg_s act_seg [2]; // Active segment registers.

	// Sequencer state.
	seq_state_e state;
	ram_addr_t cur_addr; // Address counter.
	logic dir_down; // Counting direction during playback.
	logic sel; // Index of the active segment.
	logic [15:0] step_cnt; // Step rate timer.
	logic fetch_q; // A playback word is on the RAM output.
	logic zero_hold; // Scaling inputs forced to zero until a trigger edge.
	logic trig_s1, trig_s2, trig_prev; // Trigger synchroniser and edge memory.
	logic [DATA_W-1:0] ram_rdata; // RAM output word.

	// ==========================================================
	// Decode
	wire do_write = aw_held && w_held && !bvalid;
	wire ar_take = arvalid && arready;
	wire wr_is_data = aw_addr_q == OFS_DATA;
	wire rd_is_data = araddr == OFS_DATA;
	wire update_evt = profile_change || (do_write && aw_addr_q == OFS_UPDATE && w_strb_q[0]
		&& w_data_q[UPDATE_BIT]);
	wire access_ok = act_opm == OPM_UPCONVERT || act_opm == OPM_INTERP;
	wire ser_state = state == ST_LOAD || state == ST_PLAY || state == ST_HALT;
	wire ser_wr = do_write && wr_is_data && w_strb_q == 4'hF && access_ok && ser_state;
	wire ser_rd = ar_take && rd_is_data && access_ok && ser_state;
	wire ser_op = ser_wr || ser_rd; // Serial word conversion completed.
	wire trig_rise = trig_s2 && !trig_prev;
	wire trig_fall = !trig_s2 && trig_prev;
	wire trig_edge = (trig_rise || trig_fall) && access_ok;
	wire edge_sel = trig_fall;
	seg_s cur_seg;
	seg_s edge_seg;
	assign cur_seg = act_seg[sel];
	assign edge_seg = act_seg[edge_sel];
	wire mode_ok = edge_seg.mode == PM_RAMP_UP || edge_seg.mode == PM_BIDIR
		|| edge_seg.mode == PM_CONT_BIDIR || edge_seg.mode == PM_RECIRC;
	wire start_down = trig_fall && edge_seg.mode == PM_BIDIR;
	wire [15:0] rate_m1 = (cur_seg.rate == 16'h0000) ? 16'h0000 : cur_seg.rate - 16'h0001;
	wire step_due = act_dest || step_cnt >= rate_m1;
	wire play_fire = sample_tick && state == ST_PLAY && step_due;
	wire play_fetch = play_fire && !ser_op;
	wire at_stop = cur_addr == cur_seg.stop;
	wire at_first = cur_addr == cur_seg.first;

	assign awready = !aw_held;
	assign wready = !w_held;
	assign arready = !rd_pend && !rvalid && !do_write;

	// ==========================================================
	// Bus write path: address and data are taken independently.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_held <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
			// The response follows both halves; unknown offsets answer with an error.
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= (aw_addr_q > OFS_STATUS || aw_addr_q[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Pending register writes; they do not act until an update event.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_pend <= CTRL_RST;
			seg_addr_pend[0] <= SEG_ADDR_RST;
			seg_addr_pend[1] <= SEG_ADDR_RST;
			seg_cfg_pend[0] <= SEG_CFG_RST;
			seg_cfg_pend[1] <= SEG_CFG_RST;
		end else if (do_write) begin
			unique case (aw_addr_q)
				OFS_CTRL: ctrl_pend <= apply_strb(ctrl_pend, w_data_q, w_strb_q);
				OFS_SEG0_ADDR: seg_addr_pend[0] <= apply_strb(seg_addr_pend[0], w_data_q, w_strb_q);
				OFS_SEG0_CFG: seg_cfg_pend[0] <= apply_strb(seg_cfg_pend[0], w_data_q, w_strb_q);
				OFS_SEG1_ADDR: seg_addr_pend[1] <= apply_strb(seg_addr_pend[1], w_data_q, w_strb_q);
				OFS_SEG1_CFG: seg_cfg_pend[1] <= apply_strb(seg_cfg_pend[1], w_data_q, w_strb_q);
				default: begin
					// Other offsets hold no pending state.
				end
			endcase
		end
	end

	// Active copies change only on an I/O update or profile change.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_en <= CTRL_RST[CTRL_EN_BIT];
			act_dest <= CTRL_RST[CTRL_DEST_BIT];
			act_opm <= CTRL_RST[CTRL_OPM_LSB +: 2];
			act_seg[0] <= to_seg(SEG_ADDR_RST, SEG_CFG_RST);
			act_seg[1] <= to_seg(SEG_ADDR_RST, SEG_CFG_RST);
		end else if (update_evt) begin
			act_en <= ctrl_pend[CTRL_EN_BIT];
			act_dest <= ctrl_pend[CTRL_DEST_BIT];
			act_opm <= ctrl_pend[CTRL_OPM_LSB +: 2];
			act_seg[0] <= to_seg(seg_addr_pend[0], seg_cfg_pend[0]);
			act_seg[1] <= to_seg(seg_addr_pend[1], seg_cfg_pend[1]);
		end
	end

	// ==========================================================
	// Bus read path: two cycles from address to answer, so the RAM word is ready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pend <= 1'b0;
			ar_addr_q <= 8'h00;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			rd_pend <= ar_take;
			if (ar_take) begin
				ar_addr_q <= araddr;
			end
			if (rd_pend) begin
				rvalid <= 1'b1;
				rresp <= (ar_addr_q > OFS_STATUS || ar_addr_q[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
				unique case (ar_addr_q)
					OFS_CTRL: rdata <= ctrl_pend;
					OFS_SEG0_ADDR: rdata <= seg_addr_pend[0];
					OFS_SEG0_CFG: rdata <= seg_cfg_pend[0];
					OFS_SEG1_ADDR: rdata <= seg_addr_pend[1];
					OFS_SEG1_CFG: rdata <= seg_cfg_pend[1];
					OFS_DATA: rdata <= access_ok ? ram_rdata : 32'h0000_0000;
					OFS_STATUS: begin
						rdata <= 32'h0000_0000;
						rdata[ADDR_W-1:0] <= cur_addr;
						rdata[ST_SEG_BIT] <= sel;
						rdata[ST_RUN_BIT] <= state == ST_PLAY;
						rdata[ST_LDONE_BIT] <= state == ST_LOAD_END;
						rdata[ST_EN_BIT] <= act_en;
						rdata[ST_DEST_BIT] <= act_dest;
					end
					default: rdata <= 32'h0000_0000;
				endcase
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Trigger pin synchroniser; only the second stage is looked at.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			trig_s1 <= memory_trigger_pin;
			trig_s2 <= trig_s1;
			trig_prev <= trig_s2;
		end
	end

	// ==========================================================
	// Address sequencer. An update wins over a trigger edge in the same cycle,
	// and that edge is dropped; the sequencer goes idle until the next edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cur_addr <= '0;
			dir_down <= 1'b0;
			sel <= 1'b0;
			zero_hold <= 1'b0;
		end else if (update_evt) begin
			state <= ST_IDLE;
			zero_hold <= 1'b1;
		end else if (trig_edge) begin
			sel <= edge_sel;
			zero_hold <= 1'b0;
			dir_down <= act_en && start_down;
			cur_addr <= (act_en && start_down) ? edge_seg.stop : edge_seg.first;
			if (!act_en) begin
				state <= ST_LOAD;
			end else begin
				state <= mode_ok ? ST_PLAY : ST_HALT;
			end
		end else begin
			unique case (state)
				ST_LOAD: begin
					// Each serial word moves the counter up by one until the end address.
					if (ser_op) begin
						if (at_stop) begin
							state <= ST_LOAD_END;
						end else begin
							cur_addr <= cur_addr + 1'b1;
						end
					end
				end
				ST_PLAY: begin
					if (play_fetch && !dir_down) begin
						if (!at_stop) begin
							cur_addr <= cur_addr + 1'b1;
						end else if (cur_seg.mode == PM_RECIRC) begin
							cur_addr <= cur_seg.first;
						end else if (cur_seg.mode == PM_CONT_BIDIR) begin
							dir_down <= 1'b1;
							cur_addr <= cur_addr - 1'b1;
						end else begin
							state <= ST_HALT;
						end
					end else if (play_fetch) begin
						if (!at_first) begin
							cur_addr <= cur_addr - 1'b1;
						end else if (cur_seg.mode == PM_CONT_BIDIR) begin
							dir_down <= 1'b0;
							cur_addr <= cur_addr + 1'b1;
						end else begin
							state <= ST_HALT;
						end
					end
				end
				ST_IDLE, ST_LOAD_END, ST_HALT: begin
					// Waiting for the next trigger edge.
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Step rate timer, counted in sample ticks; restarts on every trigger edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_cnt <= STEP_CNT_RST;
		end else if (trig_edge || play_fetch) begin
			step_cnt <= STEP_CNT_RST;
		end else if (sample_tick && state == ST_PLAY && !step_due) begin
			step_cnt <= step_cnt + 16'h0001;
		end
	end

	// ==========================================================
	// Storage. Serial writes go to the counter address; overlaps simply overwrite.
	waveform_ram_store u_store (
		.aclk(aclk),
		.aresetn(aresetn),
		.addr(cur_addr),
		.wr_en(ser_wr),
		.wr_data(w_data_q),
		.rd_data(ram_rdata)
	);

	// ==========================================================
	// Playback outputs, captured one cycle after the fetch.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_q <= 1'b0;
			chain_out <= '0;
			chain_valid <= 1'b0;
			scale_out <= '0;
			parallel_port_enable <= 1'b1;
		end else begin
			fetch_q <= play_fetch;
			chain_valid <= fetch_q && act_dest && act_en;
			parallel_port_enable <= !(act_en && act_dest);
			if (fetch_q && act_dest) begin
				chain_out.i <= {ram_rdata[31:16], {2{ram_rdata[31]}}};
				chain_out.q <= {ram_rdata[15:0], {2{ram_rdata[15]}}};
			end
			// Scaling inputs read zero after an update until the next trigger edge.
			if (zero_hold || !act_en) begin
				scale_out <= '0;
			end else if (fetch_q && !act_dest) begin
				scale_out.i <= ram_rdata[31:16];
				scale_out.q <= ram_rdata[15:0];
			end
		end
	end

endmodule : waveform_ram_sequencer

// ---- rtl/waveform_ram_pkg.sv ----
// Purpose: Shared constants and types for the waveform RAM sequencer.
// Assumes: One clock domain (aclk) and a 32-bit AXI4-Lite register bus.
// Notes: Offsets are byte addresses; every register is one aligned word.

package waveform_ram_pkg;

	// ==========================================================
	// Memory geometry
	localparam int RAM_DEPTH = 1024; // Number of stored words.
	localparam int ADDR_W = 10; // Word address width.
	localparam int DATA_W = 32; // Stored word width.
	localparam int HALF_W = 16; // Width of one in-phase or quadrature half.
	localparam int CHAIN_W = 18; // Width of one baseband chain channel.

	typedef logic [ADDR_W-1:0] ram_addr_t;

	// One segment register as held by the sequencer.
	typedef struct packed {
		logic [2:0] mode; // Playback mode code.
		logic [15:0] rate; // Address step rate.
		ram_addr_t stop; // End address.
		ram_addr_t first; // Start address.
	} seg_s;

	// One sample pair for the baseband chain.
	typedef struct packed {
		logic [CHAIN_W-1:0] i;
		logic [CHAIN_W-1:0] q;
	} chain_s;

	// One sample pair for the scaling multipliers (unsigned fractions).
	typedef struct packed {
		logic [HALF_W-1:0] i;
		logic [HALF_W-1:0] q;
	} scale_s;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_UPDATE = 8'h04;
	localparam logic [7:0] OFS_SEG0_ADDR = 8'h08;
	localparam logic [7:0] OFS_SEG0_CFG = 8'h0C;
	localparam logic [7:0] OFS_SEG1_ADDR = 8'h10;
	localparam logic [7:0] OFS_SEG1_CFG = 8'h14;
	localparam logic [7:0] OFS_DATA = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// ==========================================================
	// Field positions
	localparam int CTRL_EN_BIT = 0; // Memory enable: playback when set.
	localparam int CTRL_DEST_BIT = 1; // Destination: baseband chain when set.
	localparam int CTRL_OPM_LSB = 2; // Two-bit operating mode field.
	localparam int UPDATE_BIT = 0; // Writing one raises an I/O update.
	localparam int SEG_STOP_LSB = 16; // End address within the address word.
	localparam int SEG_MODE_LSB = 16; // Mode code within the config word.
	localparam int ST_SEG_BIT = 16; // Status: active segment.
	localparam int ST_RUN_BIT = 17; // Status: playback running.
	localparam int ST_LDONE_BIT = 18; // Status: load range finished.
	localparam int ST_EN_BIT = 19; // Status: active memory enable.
	localparam int ST_DEST_BIT = 20; // Status: active destination.

	// ==========================================================
	// Values after reset
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SEG_ADDR_RST = 32'h03FF_0000;
	localparam logic [31:0] SEG_CFG_RST = 32'h0000_0001;
	localparam logic [15:0] STEP_CNT_RST = 16'h0000;

	// ==========================================================
	// Codes
	localparam logic [1:0] OPM_UPCONVERT = 2'b00; // Quadrature upconvert mode.
	localparam logic [1:0] OPM_INTERP = 2'b01; // Interpolating converter mode.
	localparam logic [2:0] PM_RAMP_UP = 3'b001;
	localparam logic [2:0] PM_BIDIR = 3'b010;
	localparam logic [2:0] PM_CONT_BIDIR = 3'b011;
	localparam logic [2:0] PM_RECIRC = 3'b100;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD = 3'b001,
		ST_LOAD_END = 3'b010,
		ST_PLAY = 3'b011,
		ST_HALT = 3'b100
	} seq_state_e;

endpackage : waveform_ram_pkg

// ---- rtl/waveform_ram_store.sv ----
// Purpose: Flip-flop storage for the waveform words, one shared port.
// Assumes: The caller never asks for a read and a write of different words at once.
// Notes: The read word appears one clock after its address.

`timescale 1ns/100ps

module waveform_ram_store
	import waveform_ram_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire ram_addr_t addr,
	input wire logic wr_en,
	input wire logic [DATA_W-1:0] wr_data,
	output logic [DATA_W-1:0] rd_data
);

	// ==========================================================
	// Storage
	logic [DATA_W-1:0] mem [RAM_DEPTH]; // Word array, indexed by address.

	// Writes land on the addressed word; the last writer of a word wins.
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	// The read register is reset so the output is defined from the start.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[addr];
		end
	end

endmodule : waveform_ram_store

// ---- tb/waveform_ram_sequencer_chk.sv ----
// Purpose: Port-level assertions for the waveform RAM sequencer.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to the top module at the foot of this file.
`timescale 1ns/100ps

module waveform_ram_sequencer_chk
	import waveform_ram_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic profile_change,
	input wire logic sample_tick,
	input wire chain_s chain_out,
	input wire logic chain_valid,
	input wire scale_s scale_out,
	input wire logic parallel_port_enable
);
	// ==========================================================
	// Assertions
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CHAIN_SIGN_FILL: assert property (chain_valid |->
		chain_out.i[1:0] == {2{chain_out.i[17]}} && chain_out.q[1:0] == {2{chain_out.q[17]}})
		else $error("chain low bits do not copy the sign");
	AST_CHAIN_PORT_OFF: assert property (chain_valid |-> !parallel_port_enable)
		else $error("parallel port enabled during chain playback");
	AST_CHAIN_PACED: assert property (chain_valid |-> $past(sample_tick, 2))
		else $error("chain sample not paced by a sample tick");
	AST_UPDATE_ZERO: assert property (profile_change |-> ##[1:3] scale_out == '0)
		else $error("scaling output not zeroed after profile change");
	AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
		else $error("write response missing");
	AST_READ_ANSWER: assert property (arvalid && arready |-> ##[1:3] rvalid)
		else $error("read response missing");
	AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");
	AST_RDATA_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before taken");
	AST_ONE_READ: assert property (arvalid && arready |=> !arready)
		else $error("second read accepted while one is open");
endmodule : waveform_ram_sequencer_chk

bind waveform_ram_sequencer waveform_ram_sequencer_chk chk_u (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready), .profile_change(profile_change), .sample_tick(sample_tick),
	.chain_out(chain_out), .chain_valid(chain_valid), .scale_out(scale_out),
	.parallel_port_enable(parallel_port_enable));

// ---- tb/host_trigger_model.sv ----
// Purpose: Far-side model driving the trigger pin and the sample pacing strobe.
// Assumes: The bench commands the pin level; ticks repeat every four clocks.
// Notes: Outputs start at zero so the design never sees an unknown.
`timescale 1ns/100ps

module host_trigger_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic trig_level,
	input wire logic tick_en,
	output logic memory_trigger_pin = 1'b0,
	output logic sample_tick = 1'b0
);
	logic [1:0] phase = 2'h0; // Tick spacing counter.

	// ==========================================================
	// Pin and ticks follow the commands only while reset is released.
	always @(posedge aclk) begin
		memory_trigger_pin <= aresetn && trig_level;
		phase <= phase + 2'h1;
		sample_tick <= aresetn && tick_en && (phase == 2'h3);
	end
endmodule : host_trigger_model

// ---- tb/waveform_ram_sequencer_tb.sv ----
// Purpose: Self-checking bench for the waveform RAM sequencer.
// Assumes: 20 MHz clock, reset low for six cycles.
// Notes: Bus handshakes are sampled at the falling edge to avoid races.
`timescale 1ns/100ps

module waveform_ram_sequencer_tb;
	import waveform_ram_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, profile_change = 0;
	logic awready, wready, bvalid, arready, rvalid, chain_valid, parallel_port_enable;
	logic memory_trigger_pin, sample_tick, trig_level = 0, tick_en = 0;
	logic [1:0] bresp, rresp, r;
	chain_s chain_out;
	scale_s scale_out, last_scale = '0;
	chain_s chain_q[$];
	scale_s scale_q[$];
	int mismatches = 0, comparisons = 0;

	always #25 aclk = ~aclk;

	waveform_ram_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.memory_trigger_pin(memory_trigger_pin), .profile_change(profile_change),
		.sample_tick(sample_tick), .chain_out(chain_out), .chain_valid(chain_valid),
		.scale_out(scale_out), .parallel_port_enable(parallel_port_enable));
	host_trigger_model partner_u (.aclk(aclk), .aresetn(aresetn), .trig_level(trig_level),
		.tick_en(tick_en), .memory_trigger_pin(memory_trigger_pin), .sample_tick(sample_tick));

	// ==========================================================
	// Output capture: chain strobes and each new scaling value.
	always @(negedge aclk) begin
		if (chain_valid === 1'b1) chain_q.push_back(chain_out);
		if (scale_out !== last_scale && scale_out !== '0) scale_q.push_back(scale_out);
		last_scale = scale_out;
	end

	// Stored word pattern: halves of opposite sign, negative in-phase unless p is set.
	function automatic logic [31:0] wv(input int a, input bit p);
		wv = {(p ? 16'h7B00 : 16'h8A00) + a[15:0], (p ? 16'hC300 : 16'h1200) + a[15:0]};
	endfunction : wv

	function automatic logic [35:0] ch(input logic [31:0] w);
		ch = {w[31:16], {2{w[31]}}, w[15:0], {2{w[15]}}};
	endfunction : ch

	// ==========================================================
	// Bus and compare tasks.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ah, wh, bh;
		n = 0;
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = awvalid & awready; wh = wvalid & wready; bh = bvalid & bready; rs = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) bready <= 1'b0;
			n++;
		end while (!bh && n < 200);
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ah, rh;
		n = 0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = arvalid & arready; rh = rvalid & rready; v = rdata; rs = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
			if (rh) rready <= 1'b0;
			n++;
		end while (!rh && n < 200);
		@(posedge aclk);
	endtask : rd

	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk_word({34'h0, got}, {34'h0, exp});
	endtask : chk_resp

	// Moves the pin, then waits out the synchroniser and edge detector.
	task automatic trig(input logic lvl);
		@(posedge aclk) trig_level <= lvl;
		repeat (8) @(posedge aclk);
	endtask : trig

	task automatic results;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results

	// ==========================================================
	// Hang guard sized well above the expected run.
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		results();
	end

	// ==========================================================
	// Test sequence.
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFS_CTRL, d, r); chk_word(d, CTRL_RST);
		rd(OFS_SEG0_ADDR, d, r); chk_word(d, SEG_ADDR_RST);
		rd(OFS_SEG1_CFG, d, r); chk_word(d, SEG_CFG_RST);
		rd(8'h02, d, r); chk_resp(r, RESP_SLVERR);
		wr(8'h20, 32'h0, r); chk_resp(r, RESP_SLVERR);
		wr(OFS_SEG0_ADDR, 32'h0007_0004, r); chk_resp(r, RESP_OKAY);
		wr(OFS_SEG1_ADDR, 32'h0009_0006, r);
		wr(OFS_UPDATE, 32'h1, r);
		// Load through segment 0; the word past the end must be dropped.
		trig(1'b1);
		rd(OFS_STATUS, d, r); chk_word({d[ST_SEG_BIT], d[9:0]}, {1'b0, 10'h004});
		for (int a = 4; a <= 8; a++) wr(OFS_DATA, wv(a, 0), r);
		rd(OFS_STATUS, d, r); chk_word(d[ST_LDONE_BIT], 1'b1);
		trig(1'b0);
		rd(OFS_STATUS, d, r); chk_word({d[ST_SEG_BIT], d[9:0]}, {1'b1, 10'h006});
		for (int a = 6; a <= 9; a++) wr(OFS_DATA, wv(a, 1), r);
		trig(1'b1);
		for (int a = 4; a <= 7; a++) begin
			rd(OFS_DATA, d, r); chk_word(d, wv(a, a >= 6));
		end
		// Ramp-up playback into the baseband chain from segment 1.
		wr(OFS_SEG0_CFG, 32'h0001_0001, r);
		wr(OFS_SEG1_CFG, 32'h0001_0001, r);
		wr(OFS_CTRL, 32'h0000_0003, r);
		rd(OFS_STATUS, d, r); chk_word(d[ST_EN_BIT], 1'b0);
		wr(OFS_UPDATE, 32'h1, r);
		rd(OFS_STATUS, d, r); chk_word(d[ST_DEST_BIT:ST_EN_BIT], 2'b11);
		chk_word(parallel_port_enable, 1'b0);
		tick_en <= 1'b1;
		trig(1'b0);
		repeat (60) @(posedge aclk);
		chk_word(chain_q.size(), 4);
		for (int a = 6; a <= 9 && chain_q.size() > 0; a++) chk_word(chain_q.pop_front(), ch(wv(a, 1)));
		// Bidirectional playback to the scaling multipliers, enacted by a profile change.
		wr(OFS_SEG0_CFG, 32'h0002_0002, r);
		wr(OFS_SEG1_CFG, 32'h0002_0002, r);
		wr(OFS_CTRL, 32'h0000_0001, r);
		@(posedge aclk) profile_change <= 1'b1;
		@(posedge aclk) profile_change <= 1'b0;
		rd(OFS_STATUS, d, r); chk_word(d[ST_DEST_BIT:ST_EN_BIT], 2'b01);
		scale_q.delete();
		trig(1'b1);
		repeat (40) @(posedge aclk);
		chk_word(scale_q.size() >= 2, 1'b1);
		if (scale_q.size() >= 2) begin
			chk_word(scale_q[0], wv(4, 0));
			chk_word(scale_q[1], wv(5, 0));
		end
		scale_q.delete();
		trig(1'b0);
		repeat (30) @(posedge aclk);
		chk_word(scale_q.size() >= 2, 1'b1);
		if (scale_q.size() >= 2) begin
			chk_word(scale_q[0], wv(9, 1));
			chk_word(scale_q[1], wv(8, 1));
		end
		wr(OFS_SEG0_CFG, 32'h0005_0002, r);
		wr(OFS_UPDATE, 32'h1, r);
		trig(1'b1);
		rd(OFS_STATUS, d, r); chk_word(d[ST_RUN_BIT], 1'b0);
		// A disallowed operating mode shuts memory access off.
		tick_en <= 1'b0;
		wr(OFS_CTRL, 32'h0000_0008, r);
		wr(OFS_UPDATE, 32'h1, r);
		trig(1'b0);
		rd(OFS_DATA, d, r); chk_word(d, 32'h0000_0000);
		results();
	end
endmodule : waveform_ram_sequencer_tb
